/* pkg/scca_pkg.sv */
`default_nettype none
// ***************************************************************
// Shared constants and types of the serial command core
// ***************************************************************
package scca_pkg;
    // Word layout
    localparam int WORD_W = 16;
    localparam int CMD_MSB = 15;
    localparam int CMD_LSB = 8;
    localparam int DATA_MSB = 7;
    localparam int READ_BIT = 15;
    // Command codes
    localparam logic [6:0] ADDR_NULL = 7'h00;
    localparam logic [6:0] ADDR_GLOBAL_CUR = 7'h02;
    localparam logic [6:0] ADDR_CONFIG = 7'h04;
    localparam logic [6:0] ADDR_MASK = 7'h06;
    localparam logic [6:0] ADDR_PORTCFG_HI = 7'h0f;
    localparam logic [6:0] ADDR_CUR_FIRST = 7'h12;
    localparam logic [6:0] ADDR_CUR_LAST = 7'h1f;
    // Configuration fields
    localparam int CFG_RUN_POS = 0;
    localparam int CFG_INDIV_POS = 6;
    localparam int CFG_MON_POS = 7;
    // Reset values
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_GLOBAL_CUR = 8'h00;
    localparam logic [7:0] RST_CUR = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_PORTCFG = 8'haa;
    localparam int NUM_CUR = 14;
    localparam int NUM_MON = 7;
    // Latched command word
    typedef struct packed {
        logic isRead;
        logic [6:0] addr;
        logic [7:0] data;
    } scca_word_t;
endpackage
`default_nettype wire

/* hdl/scca_core.sv */
// Notes on behaviour
// - Word: command byte high, data byte low
// - Data out lags input by 15.5 clocks
// - Null command code does nothing
// - Select low: shift data on rising clock
// - Select high: rising edges ignored, falling edges still reload data out from the top bit
// - Select rise latches word and executes
// - Extra bits: only last sixteen kept
// - Read: top bit set, dummy data dropped
// - Read loads addressed register into low byte
// - Reset clears controls except port config (8'haa), enters shutdown
// - Individual select picks per-segment current
// - Seven-bit mask selects monitored ports
// - Monitoring ignores port direction
// - Monitor write takes seven-bit snapshot
// - Monitor write arms, alert goes low
// - Armed mismatch latches alert high
// - Mask access alone clears alert
// - Cleared alert stays disarmed until rewrite
`timescale 1ns/100ps
`default_nettype none
module scca_core
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic serialClk,
    input wire logic chipSelectN,
    input wire logic serialDataIn,
    output logic serialDataOut,
    input wire logic [6:0] monitoredPorts,
    output logic alertPort,
    output logic shutdownMode,
    output logic individualCurrentSelect,
    output logic [7:0] globalLedCurrent,
    output logic [111:0] segmentCurrents,
    output logic [1:0] alertPortConfig
);
    // ***************************************************************
    // Input synchronisers
    // ***************************************************************
    // Three stages; a change counts once the last two agree
    logic [2:0] sclkSync_q;
    logic [2:0] csSync_q;
    logic [2:0] dinSync_q;
    logic [6:0] monSync1_q;
    logic [6:0] monSync2_q;
    logic [6:0] monSync3_q;
    logic sclkLvl_q; // Filtered clock level
    logic csLvl_q; // Filtered select level
    logic [6:0] monLvl_q; // Filtered port levels

    // Synchroniser chain
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            sclkSync_q <= 3'h0;
            csSync_q <= 3'h7;
            dinSync_q <= 3'h0;
            monSync1_q <= 7'h00;
            monSync2_q <= 7'h00;
            monSync3_q <= 7'h00;
        end
        else
        begin
            sclkSync_q <= {sclkSync_q[1:0], serialClk};
            csSync_q <= {csSync_q[1:0], chipSelectN};
            dinSync_q <= {dinSync_q[1:0], serialDataIn};
            monSync1_q <= monitoredPorts;
            monSync2_q <= monSync1_q;
            monSync3_q <= monSync2_q;
        end
    end

    // Agreement filters; the first stage feeds only the second
    wire sclkAgree = sclkSync_q[1] == sclkSync_q[2];
    wire csAgree = csSync_q[1] == csSync_q[2];
    wire [6:0] monAgree = ~(monSync2_q ^ monSync3_q);

    // Filtered levels
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            sclkLvl_q <= 1'b0;
            csLvl_q <= 1'b1;
            monLvl_q <= 7'h00;
        end
        else
        begin
            if (sclkAgree)
                sclkLvl_q <= sclkSync_q[2];
            if (csAgree)
                csLvl_q <= csSync_q[2];
            monLvl_q <= (monAgree & monSync3_q) | (~monAgree & monLvl_q);
        end
    end

    // ***************************************************************
    // Edge decode
    // ***************************************************************
    wire sclkRise = sclkAgree && sclkSync_q[2] && !sclkLvl_q;
    wire sclkFall = sclkAgree && !sclkSync_q[2] && sclkLvl_q;
    wire csRise = csAgree && csSync_q[2] && !csLvl_q;
    wire selected = !csLvl_q;
    // Data is stable at the rising edge, and three stages delay it as far as the clock
    wire shiftEn = selected && sclkRise;

    // ***************************************************************
    // Shift register and holding latch
    // ***************************************************************
    logic [15:0] shift_q; // Serial shift register
    logic [15:0] shift_d;
    scca_pkg::scca_word_t latch_q; // Holding latch
    logic execPulse_q; // Set on the same edge that loads the latch
    logic [7:0] readData;

    // Read loads the low byte once the latch is decoded
    wire loadRead = execPulse_q && latch_q.isRead;

    // Next value of the shift register
    always_comb
    begin
        shift_d = shift_q;
        if (shiftEn)
            shift_d = {shift_q[14:0], dinSync_q[2]};
        else if (loadRead)
            shift_d = {shift_q[15:8], readData};
    end

    // Register update; older bits simply fall off the top
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            shift_q <= 16'h0000;
            latch_q <= '0;
            execPulse_q <= 1'b0;
        end
        else
        begin
            shift_q <= shift_d;
            execPulse_q <= csRise;
            if (csRise)
                latch_q <= shift_q;
        end
    end

    // Output changes on the falling edge: sixteen stages less half a clock
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            serialDataOut <= 1'b0;
        else if (sclkFall)
            serialDataOut <= shift_q[15];
    end

    // ***************************************************************
    // Control registers
    // ***************************************************************
    logic [7:0] config_q;
    logic [7:0] globalCur_q;
    logic [6:0] mask_q;
    logic [7:0] portCfgHi_q; // Port group holding the alert pin
    logic [7:0] cur_q [scca_pkg::NUM_CUR];
    logic [6:0] snapshot_q;
    logic armed_q;
    logic alert_q;

    wire isWrite = execPulse_q && !latch_q.isRead;
    wire [6:0] addr = latch_q.addr;
    // Null code matches nothing below, so it has no effect
    wire wrConfig = isWrite && addr == scca_pkg::ADDR_CONFIG;
    wire wrGlobal = isWrite && addr == scca_pkg::ADDR_GLOBAL_CUR;
    wire wrMask = isWrite && addr == scca_pkg::ADDR_MASK;
    wire wrPortCfg = isWrite && addr == scca_pkg::ADDR_PORTCFG_HI;
    wire maskAccess = execPulse_q && addr == scca_pkg::ADDR_MASK;
    wire monSet = latch_q.data[scca_pkg::CFG_MON_POS];
    wire [4:0] curIdx = 5'(addr - scca_pkg::ADDR_CUR_FIRST);
    wire inCurRange = addr >= scca_pkg::ADDR_CUR_FIRST && addr <= scca_pkg::ADDR_CUR_LAST;

    // Read mux; the read bit itself is dropped from the address
    assign readData =
        (addr == scca_pkg::ADDR_CONFIG) ? config_q :
        (addr == scca_pkg::ADDR_GLOBAL_CUR) ? globalCur_q :
        (addr == scca_pkg::ADDR_MASK) ? {1'b0, mask_q} :
        (addr == scca_pkg::ADDR_PORTCFG_HI) ? portCfgHi_q :
        inCurRange ? cur_q[curIdx[3:0]] : 8'h00;

    // Per-segment current registers
    genvar gi;
    generate
        for (gi = 0; gi < scca_pkg::NUM_CUR; gi++)
        begin : g_cur
            always_ff @(posedge mclk or negedge resetn)
            begin
                if (!resetn)
                    cur_q[gi] <= scca_pkg::RST_CUR;
                else if (isWrite && inCurRange && curIdx[3:0] == 4'(gi))
                    cur_q[gi] <= latch_q.data;
            end
            assign segmentCurrents[gi*8 +: 8] = cur_q[gi];
        end
    endgenerate

    // Plain control registers; reset leaves shutdown selected
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            config_q <= scca_pkg::RST_CONFIG;
            globalCur_q <= scca_pkg::RST_GLOBAL_CUR;
            mask_q <= scca_pkg::RST_MASK[6:0];
            portCfgHi_q <= scca_pkg::RST_PORTCFG;
        end
        else
        begin
            if (wrConfig)
                config_q <= latch_q.data;
            if (wrGlobal)
                globalCur_q <= latch_q.data;
            if (wrMask)
                mask_q <= latch_q.data[6:0];
            if (wrPortCfg)
                portCfgHi_q <= latch_q.data;
        end
    end

    // ***************************************************************
    // Transition detector
    // ***************************************************************
    // Levels only, so direction of the port does not matter
    wire mismatch = |((monLvl_q ^ snapshot_q) & mask_q);
    // Pulses shorter than one mclk period are filtered out by the synchroniser

    // Snapshot, arm and alert; catching a change beats a mask-access clear in the same cycle, a monitor write beats both
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            snapshot_q <= 7'h00;
            armed_q <= 1'b0;
            alert_q <= 1'b0;
        end
        else
        begin
            if (wrConfig && monSet)
                snapshot_q <= monLvl_q;
            if (wrConfig)
                armed_q <= monSet;
            else if (armed_q && mismatch)
                armed_q <= 1'b0;
            if (wrConfig && monSet)
                alert_q <= 1'b0;
            else if (armed_q && mismatch)
                alert_q <= 1'b1;
            else if (maskAccess)
                alert_q <= 1'b0;
        end
    end

    // ***************************************************************
    // Registered outputs
    // ***************************************************************
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            alertPort <= 1'b0;
            shutdownMode <= 1'b1;
            individualCurrentSelect <= 1'b0;
            globalLedCurrent <= scca_pkg::RST_GLOBAL_CUR;
            alertPortConfig <= scca_pkg::RST_PORTCFG[7:6];
        end
        else
        begin
            alertPort <= alert_q;
            shutdownMode <= !config_q[scca_pkg::CFG_RUN_POS];
            individualCurrentSelect <= config_q[scca_pkg::CFG_INDIV_POS];
            globalLedCurrent <= globalCur_q;
            alertPortConfig <= portCfgHi_q[7:6];
        end
    end

    // ***************************************************************
    // Assertions
    // ***************************************************************
    sequence s_monWrite;
        wrConfig && monSet;
    endsequence
    sequence s_alertLow;
        !alertPort [*1];
    endsequence

    a_monitor_arms: assert property (@(posedge mclk) disable iff (!resetn)
        s_monWrite |=> armed_q ##1 s_alertLow)
        else $error("monitor write did not arm");
    a_mismatch_latches: assert property (@(posedge mclk) disable iff (!resetn)
        armed_q && mismatch && !wrConfig |=> alert_q && !armed_q)
        else $error("mismatch not latched");
    a_alert_holds: assert property (@(posedge mclk) disable iff (!resetn)
        alert_q && !maskAccess && !wrConfig |=> alert_q)
        else $error("alert cleared without mask access");
    a_disarm_stays: assert property (@(posedge mclk) disable iff (!resetn)
        !armed_q && !wrConfig |=> !armed_q)
        else $error("rearmed without config write");
    a_snapshot_take: assert property (@(posedge mclk) disable iff (!resetn)
        s_monWrite |=> snapshot_q == $past(monLvl_q))
        else $error("snapshot not taken");
    a_shift_hold: assert property (@(posedge mclk) disable iff (!resetn)
        csLvl_q && !loadRead |=> shift_q == $past(shift_q))
        else $error("shift moved while deselected");
    a_latch_load: assert property (@(posedge mclk) disable iff (!resetn)
        csRise |=> latch_q == $past(shift_q) ##0 execPulse_q)
        else $error("latch not loaded at select rise");
    a_read_load: assert property (@(posedge mclk) disable iff (!resetn)
        loadRead |=> shift_q[7:0] == $past(readData))
        else $error("read data not loaded");
    a_shift_in: assert property (@(posedge mclk) disable iff (!resetn)
        shiftEn |=> shift_q[0] == $past(dinSync_q[2]) && shift_q[15:1] == $past(shift_q[14:0]))
        else $error("bit not shifted in");
    a_dout_fall: assert property (@(posedge mclk) disable iff (!resetn)
        sclkFall |=> serialDataOut == $past(shift_q[15]))
        else $error("data out not updated on falling edge");
endmodule
`default_nettype wire

/* tb/scca_host.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Host master model on the serial link
// ****************************************
module scca_host
(
    input wire logic mclk,
    output logic serialClk,
    output logic chipSelectN,
    output logic serialDataIn,
    input wire logic serialDataOut
);
    // Idle: clock parked low, select high
    initial
    begin
        serialClk = 1'b0;
        chipSelectN = 1'b1;
        serialDataIn = 1'b0;
    end
    // One frame of n bits, first bit sent is w[n-1]; r keeps the last 16 bits seen
    task automatic frame(input logic [31:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        @(posedge mclk);
        chipSelectN <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int i = n - 1; i >= 0; i--)
        begin
            serialDataIn <= w[i];
            repeat (4) @(posedge mclk);
            serialClk <= 1'b1;
            repeat (4) @(posedge mclk);
            // Sampled at the end of the high phase, far from the update after the fall
            r = {r[14:0], serialDataOut};
            serialClk <= 1'b0;
        end
        repeat (4) @(posedge mclk);
        chipSelectN <= 1'b1;
        // Released data line shows the inverse, never a stale copy
        serialDataIn <= ~serialDataIn;
        // Latch, execute and output update, which also covers the select high gap
        repeat (10) @(posedge mclk);
    endtask
    // Clock traffic meant for other parts while select stays high
    task automatic stray(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk);
            serialDataIn <= ~serialDataIn;
            repeat (4) @(posedge mclk);
            serialClk <= 1'b1;
            repeat (4) @(posedge mclk);
            serialClk <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* tb/tb_scca_core.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Self-checking bench of the serial command core
// ****************************************
module tb_scca_core;
    logic mclk = 1'b0; // System clock, 40 MHz
    logic resetn = 1'b0; // Power-up stand-in
    logic serialClk, chipSelectN, serialDataIn, serialDataOut;
    logic alertPort, shutdownMode, individualCurrentSelect;
    logic [6:0] monitoredPorts = 7'h00; // Levels of the watched ports
    logic [7:0] globalLedCurrent, d;
    logic [111:0] segmentCurrents, expSeg;
    logic [1:0] alertPortConfig;
    logic [15:0] r; // Bits seen on data out in the last frame
    int errors = 0;
    int checksDone = 0;
    // Clock
    always #12.5 mclk = ~mclk;
    scca_host host_u (.mclk(mclk), .serialClk(serialClk), .chipSelectN(chipSelectN),
        .serialDataIn(serialDataIn), .serialDataOut(serialDataOut));
    scca_core dut_u (.mclk(mclk), .resetn(resetn), .serialClk(serialClk), .chipSelectN(chipSelectN),
        .serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .monitoredPorts(monitoredPorts),
        .alertPort(alertPort), .shutdownMode(shutdownMode), .individualCurrentSelect(individualCurrentSelect),
        .globalLedCurrent(globalLedCurrent), .segmentCurrents(segmentCurrents),
        .alertPortConfig(alertPortConfig));
    // ****************************************
    // Shared tasks
    // ****************************************
    // Compare and count; case inequality so an unknown never matches
    task automatic check(input string what, input logic [111:0] seen, input logic [111:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Plain 16-bit command
    task automatic wr(input logic [7:0] cmd, input logic [7:0] dat);
        host_u.frame({16'h0000, cmd, dat}, 16, r);
    endtask
    // Read: query frame, then a null frame that carries the answer back
    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        host_u.frame({16'h0000, 1'b1, a, 8'h00}, 16, r);
        host_u.frame(32'h0, 16, r);
        check("read echo", r[15:8], {1'b1, a});
        v = r[7:0];
    endtask
    // Verdict, reached from the tests and from the watchdog
    task automatic results();
        $display("checks %0d errors %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog, 20k cycles, about three times what the tests need
    initial
    begin
        #500_000;
        errors++;
        $display("ERROR watchdog expired");
        results();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        check("shutdown", shutdownMode, 1'b1);
        check("individual", individualCurrentSelect, 1'b0);
        check("global", globalLedCurrent, scca_pkg::RST_GLOBAL_CUR);
        check("segments", segmentCurrents, '0);
        check("alert", alertPort, 1'b0);
        check("alert cfg", alertPortConfig, scca_pkg::RST_PORTCFG[7:6]);
        $display("test done: reset");
        // Write, null, stray clocks, then echo and read back
        wr({1'b0, scca_pkg::ADDR_GLOBAL_CUR}, 8'h37);
        check("global", globalLedCurrent, 8'h37);
        wr(8'h00, 8'hff);
        check("echo", r, 16'h0237);
        check("global after null", globalLedCurrent, 8'h37);
        host_u.stray(5);
        wr(8'h00, 8'h00);
        check("echo after stray", r, 16'h00ff);
        rd(scca_pkg::ADDR_GLOBAL_CUR, d);
        check("read global", d, 8'h37);
        $display("test done: access");
        // Over-long frame: only the last 16 bits act
        host_u.frame(32'h00a50441, 24, r);
        // Old low byte, then the first eight new bits after 15.5 clocks
        check("echo long frame", r, 16'h00a5);
        check("shutdown", shutdownMode, 1'b0);
        check("individual", individualCurrentSelect, 1'b1);
        expSeg = '0;
        for (int i = 0; i < scca_pkg::NUM_CUR; i++)
        begin
            wr(8'h12 + 8'(i), 8'h20 + 8'(i));
            expSeg[8 * i +: 8] = 8'h20 + 8'(i);
        end
        check("segments", segmentCurrents, expSeg);
        // Read-back of a current, the configuration and an unmapped code
        rd(7'h15, d);
        check("read current", d, 8'h23);
        rd(scca_pkg::ADDR_CONFIG, d);
        check("read config", d, 8'h41);
        rd(7'h40, d);
        check("read unmapped", d, 8'h00);
        $display("test done: currents");
        // Alert: set port as output, mask port 0, arm
        wr(8'h0f, 8'h40);
        check("alert cfg", alertPortConfig, 2'b01);
        wr({1'b0, scca_pkg::ADDR_MASK}, 8'h01);
        wr({1'b0, scca_pkg::ADDR_CONFIG}, 8'hc1);
        check("alert armed", alertPort, 1'b0);
        // Masked-out port changes: nothing
        monitoredPorts <= 7'h02;
        repeat (10) @(posedge mclk);
        check("alert unmasked", alertPort, 1'b0);
        // Brief pulse on the watched port latches, return does not clear
        monitoredPorts <= 7'h03;
        repeat (4) @(posedge mclk);
        monitoredPorts <= 7'h02;
        repeat (10) @(posedge mclk);
        check("alert pulse", alertPort, 1'b1);
        rd(scca_pkg::ADDR_MASK, d);
        check("mask read", d, 8'h01);
        check("alert cleared", alertPort, 1'b0);
        // One-shot: no new alert until re-armed
        monitoredPorts <= 7'h03;
        repeat (10) @(posedge mclk);
        check("alert disarmed", alertPort, 1'b0);
        wr({1'b0, scca_pkg::ADDR_CONFIG}, 8'hc1);
        repeat (10) @(posedge mclk);
        check("alert new snapshot", alertPort, 1'b0);
        monitoredPorts <= 7'h02;
        repeat (10) @(posedge mclk);
        check("alert rearmed", alertPort, 1'b1);
        // Other accesses leave the alert alone; a mask write clears it
        wr({1'b0, scca_pkg::ADDR_GLOBAL_CUR}, 8'h37);
        rd(scca_pkg::ADDR_CONFIG, d);
        check("read config armed", d, 8'hc1);
        check("alert other access", alertPort, 1'b1);
        wr({1'b0, scca_pkg::ADDR_MASK}, 8'h01);
        check("alert mask write", alertPort, 1'b0);
        // Re-arm on the present levels and trip again for the forced-low case
        wr({1'b0, scca_pkg::ADDR_CONFIG}, 8'hc1);
        monitoredPorts <= 7'h03;
        repeat (10) @(posedge mclk);
        check("alert tripped", alertPort, 1'b1);
        // Config write with monitor set forces the alert low
        wr({1'b0, scca_pkg::ADDR_CONFIG}, 8'hc1);
        check("alert forced low", alertPort, 1'b0);
        // Monitor cleared: detection off
        wr({1'b0, scca_pkg::ADDR_CONFIG}, 8'h41);
        monitoredPorts <= 7'h02;
        repeat (10) @(posedge mclk);
        check("alert monitor off", alertPort, 1'b0);
        $display("test done: alert");
        results();
    end
endmodule
`default_nettype wire
